//--- core/radio_state_ctrl.sv
// Purpose: radio operating-state controller with clear channel gating
// Assumes: datapath inputs are on sys_clk; one clock per reference period
// Notes: APB slave answers with one wait-free access phase
//
// Decided for this implementation: the APB register port and the register offsets.
module radio_state_ctrl
	import radio_ctrl_pkg::*;
#(
	parameter int CAL_CYCLES_P = CAL_CYCLES
)(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// apb slave
	input  wire logic [7:0] paddr,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	// receive datapath
	input  wire logic [7:0] rssi,
	input  wire logic       rssi_valid,
	input  wire logic       cs_abs,
	input  wire logic       pkt_receiving,
	input  wire logic       sync_found,
	input  wire logic       pqt_reached,
	input  wire logic       rx_pkt_done,
	input  wire logic       rx_timer_expired,
	// transmit datapath
	input  wire logic       tx_pkt_done,
	input  wire logic       tx_underflow,
	// radio control and pins
	output logic [4:0]      radio_state,
	output logic            synth_on,
	output logic            synth_cal,
	output logic            rx_enable,
	output logic            tx_enable,
	output logic            port1_pin5,
	output logic            port1_pin6,
	output logic            port1_pin7
);
	timer_if tmr ();

	transition_timer transition_timer_i (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.t       (tmr)
	);

	radio_state_t      state_reg, state_next;
	radio_state_t      target_reg, target_next;
	logic [7:0]        cfg0_reg, cfg1_reg, cfg2_reg, gain1_reg;
	logic [11:0]       pincfg_reg;
	logic [3:0]        strobe_code_reg;
	logic              strobe_valid_reg;
	logic              pready_reg, pslverr_reg;
	logic [31:0]       prdata_reg;
	logic [7:0]        rssi_prev_reg;
	logic              rssi_seen_reg, rel_cs_reg, rx_first_reg;
	logic [1:0]        auto_idle_cnt_reg;
	logic [2:0]        pin_reg;
	logic [4:0]        state_num_reg;
	logic              synth_reg, cal_reg, rxen_reg, txen_reg;

	logic [1:0]        auto_cal, cca_policy, after_rx, after_tx, rel_sel;
	logic              carrier_sense, cca_ok, rx_stay, early_exit, auto_idle, cal_at_end;
	logic              go_idle, go_rx, go_tx, go_synth, go_cal;
	logic              wr_en, setup;
	logic signed [8:0] rssi_diff, rel_step;

	assign auto_cal   = cfg0_reg[AUTOCAL_LSB +: 2];
	assign cca_policy = cfg1_reg[CCA_LSB +: 2];
	assign after_rx   = cfg1_reg[RXOFF_LSB +: 2];
	assign after_tx   = cfg1_reg[TXOFF_LSB +: 2];
	assign rel_sel    = gain1_reg[RELCS_LSB +: 2];

	assign go_idle  = strobe_valid_reg && strobe_code_reg == STB_IDLE;
	assign go_rx    = strobe_valid_reg && strobe_code_reg == STB_RX;
	assign go_tx    = strobe_valid_reg && strobe_code_reg == STB_TX;
	assign go_synth = strobe_valid_reg && strobe_code_reg == STB_SYNTH;
	assign go_cal   = strobe_valid_reg && strobe_code_reg == STB_CAL;

	// apb: prdata, pready and pslverr are prepared in the setup cycle
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready_reg;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == ADDR_STROBE) || (a == ADDR_CFG0) || (a == ADDR_CFG1) || (a == ADDR_CFG2) ||
		         (a == ADDR_GAIN1) || (a == ADDR_PINCFG) || (a == ADDR_STATE) || (a == ADDR_STATUS);
	endfunction : mapped

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else begin
			pready_reg  <= setup && !pready_reg;
			pslverr_reg <= setup && !mapped(paddr);
			prdata_reg  <= '0;
			if (setup && !pwrite) begin
				case (paddr)
					ADDR_CFG0:   prdata_reg <= {24'h000000, cfg0_reg};
					ADDR_CFG1:   prdata_reg <= {24'h000000, cfg1_reg};
					ADDR_CFG2:   prdata_reg <= {24'h000000, cfg2_reg};
					ADDR_GAIN1:  prdata_reg <= {24'h000000, gain1_reg};
					ADDR_PINCFG: prdata_reg <= {20'h00000, pincfg_reg};
					ADDR_STATE:  prdata_reg <= {27'h0000000, state_num_reg};
					ADDR_STATUS: prdata_reg <= {28'h0000000, cal_reg, rel_cs_reg, carrier_sense, cca_ok};
					default:     prdata_reg <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cfg0_reg   <= CFG0_RST;
			cfg1_reg   <= CFG1_RST;
			cfg2_reg   <= CFG2_RST;
			gain1_reg  <= GAIN1_RST;
			pincfg_reg <= PINCFG_RST;
		end else if (wr_en) begin
			case (paddr)
				ADDR_CFG0:   cfg0_reg   <= pwdata[7:0];
				ADDR_CFG1:   cfg1_reg   <= pwdata[7:0];
				ADDR_CFG2:   cfg2_reg   <= pwdata[7:0];
				ADDR_GAIN1:  gain1_reg  <= pwdata[7:0];
				ADDR_PINCFG: pincfg_reg <= pwdata[11:0];
				default:     ;
			endcase
		end
	end

	// strobes act one cycle after the write completes; unknown codes are dropped
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strobe_valid_reg <= 1'b0;
			strobe_code_reg  <= '0;
		end else begin
			strobe_valid_reg <= wr_en && paddr == ADDR_STROBE &&
			                    pwdata[3:0] >= STB_CAL && pwdata[3:0] <= STB_IDLE;
			strobe_code_reg  <= pwdata[3:0];
		end
	end

	// relative carrier sense: set on a rise, cleared on an equal fall
	always_comb begin
		rssi_diff = $signed({rssi[7], rssi}) - $signed({rssi_prev_reg[7], rssi_prev_reg});
		case (rel_sel)
			2'h1:    rel_step = REL_STEP_6DB;
			2'h2:    rel_step = REL_STEP_10DB;
			default: rel_step = REL_STEP_14DB;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rssi_prev_reg <= '0;
			rssi_seen_reg <= 1'b0;
			rel_cs_reg    <= 1'b0;
		end else if (rel_sel == 2'h0) begin
			rel_cs_reg    <= 1'b0;
			rssi_seen_reg <= 1'b0;
		end else if (rssi_valid) begin
			rssi_prev_reg <= rssi;
			rssi_seen_reg <= 1'b1;
			if (rssi_seen_reg && rssi_diff >= rel_step) begin
				rel_cs_reg <= 1'b1;
			end else if (rssi_seen_reg && rssi_diff <= -rel_step) begin
				rel_cs_reg <= 1'b0;
			end
		end
	end

	assign carrier_sense = cs_abs || rel_cs_reg;

	always_comb begin
		case (cca_policy)
			2'h0:    cca_ok = 1'b1;
			2'h1:    cca_ok = !carrier_sense;
			2'h2:    cca_ok = !pkt_receiving;
			default: cca_ok = !carrier_sense && !pkt_receiving;
		endcase
	end

	// only the first rssi sample of each rx visit may end it early
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rx_first_reg <= 1'b0;
		end else if (state_next == ST_RX && state_reg != ST_RX) begin
			rx_first_reg <= 1'b1;
		end else if (rssi_valid) begin
			rx_first_reg <= 1'b0;
		end
	end

	assign rx_stay    = sync_found || (cfg2_reg[QUAL_BIT] && pqt_reached);
	assign early_exit = cfg2_reg[EARLY_BIT] && rx_first_reg && rssi_valid && !carrier_sense;
	assign cal_at_end = auto_cal == CAL_END || (auto_cal == CAL_END4 && auto_idle_cnt_reg == 2'h3);

	always_comb begin
		state_next  = state_reg;
		target_next = target_reg;
		auto_idle   = 1'b0;
		tmr.load    = 1'b0;
		tmr.clear   = 1'b0;
		tmr.value   = '0;
		if (go_idle) begin
			state_next = ST_IDLE;
			tmr.clear  = 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (go_rx || go_tx || go_synth) begin
						target_next = go_rx ? ST_RX : (go_tx ? ST_TX : ST_SYNTH_READY);
						tmr.load    = 1'b1;
						if (auto_cal == CAL_START) begin
							state_next = ST_CAL;
							tmr.value  = TMR_W'(CAL_CYCLES_P);
						end else begin
							state_next = ST_SETTLE;
							tmr.value  = TMR_W'(SETTLE_CYCLES);
						end
					end else if (go_cal) begin
						state_next  = ST_CAL;
						target_next = ST_IDLE;
						tmr.load    = 1'b1;
						tmr.value   = TMR_W'(CAL_CYCLES_P);
					end
				end
				ST_CAL: begin
					if (tmr.done) begin
						state_next = (target_reg == ST_IDLE) ? ST_IDLE : ST_SETTLE;
						if (target_reg != ST_IDLE) begin
							tmr.load  = 1'b1;
							tmr.value = TMR_W'(SETTLE_CYCLES);
						end
					end
				end
				ST_SETTLE, ST_TX_TO_RX, ST_RX_TO_TX: begin
					if (tmr.done) begin
						state_next = target_reg;
					end
				end
				ST_RX: begin
					if ((go_tx || go_synth) && cca_ok) begin
						state_next  = ST_RX_TO_TX;
						target_next = go_tx ? ST_TX : ST_SYNTH_READY;
						tmr.load    = 1'b1;
						tmr.value   = TMR_W'(RX_TX_CYCLES);
					end else if (rx_pkt_done) begin
						case (after_rx)
							OFF_SYNTH, OFF_TX: begin
								state_next  = ST_RX_TO_TX;
								target_next = (after_rx == OFF_TX) ? ST_TX : ST_SYNTH_READY;
								tmr.load    = 1'b1;
								tmr.value   = TMR_W'(RX_TX_CYCLES);
							end
							OFF_RX:  state_next = ST_RX;
							default: auto_idle = 1'b1;
						endcase
					end else if ((rx_timer_expired && !rx_stay) || early_exit) begin
						auto_idle = 1'b1;
					end
				end
				ST_TX: begin
					if (go_rx) begin
						state_next  = ST_TX_TO_RX;
						target_next = ST_RX;
						tmr.load    = 1'b1;
						tmr.value   = TMR_W'(TX_RX_CYCLES);
					end else if (tx_underflow) begin
						state_next = ST_TX_UNDERFLOW;
					end else if (tx_pkt_done) begin
						case (after_tx)
							OFF_SYNTH: state_next = ST_SYNTH_READY;
							OFF_TX:    state_next = ST_TX;
							OFF_RX: begin
								state_next  = ST_TX_TO_RX;
								target_next = ST_RX;
								tmr.load    = 1'b1;
								tmr.value   = TMR_W'(TX_RX_CYCLES);
							end
							default:   auto_idle = 1'b1;
						endcase
					end
				end
				ST_SYNTH_READY: begin
					if (go_tx) begin
						state_next = ST_TX;
					end else if (go_rx) begin
						state_next  = ST_TX_TO_RX;
						target_next = ST_RX;
						tmr.load    = 1'b1;
						tmr.value   = TMR_W'(TX_RX_CYCLES);
					end
				end
				ST_TX_UNDERFLOW: state_next = ST_TX_UNDERFLOW;
				default:         state_next = ST_IDLE;
			endcase
			if (auto_idle) begin
				target_next = ST_IDLE;
				if (cal_at_end) begin
					state_next = ST_CAL;
					tmr.load   = 1'b1;
					tmr.value  = TMR_W'(CAL_CYCLES_P);
				end else begin
					state_next = ST_IDLE;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg  <= ST_IDLE;
			target_reg <= ST_IDLE;
		end else begin
			state_reg  <= state_next;
			target_reg <= target_next;
		end
	end

	// counts automatic ends for the every-fourth policy
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			auto_idle_cnt_reg <= '0;
		end else if (auto_idle && !go_idle) begin
			auto_idle_cnt_reg <= auto_idle_cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_num_reg <= state_number(ST_IDLE);
			synth_reg     <= 1'b0;
			cal_reg       <= 1'b0;
			rxen_reg      <= 1'b0;
			txen_reg      <= 1'b0;
		end else begin
			state_num_reg <= state_number(state_next);
			synth_reg     <= state_next != ST_IDLE && state_next != ST_TX_UNDERFLOW;
			cal_reg       <= state_next == ST_CAL;
			rxen_reg      <= state_next == ST_RX;
			txen_reg      <= state_next == ST_TX;
		end
	end

	function automatic logic pin_value(input logic [3:0] sel, input logic cca, input logic cs,
	                                   input logic preamble_quality_threshold);
		case (sel)
			PIN_SEL_CCA: pin_value = cca;
			PIN_SEL_CS:  pin_value = cs;
			PIN_SEL_PQT: pin_value = preamble_quality_threshold;
			default:     pin_value = 1'b0;
		endcase
	endfunction : pin_value

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					pin_reg[gi] <= 1'b0;
				end else begin
					pin_reg[gi] <= pin_value(pincfg_reg[gi*PIN_W +: PIN_W], cca_ok, carrier_sense,
					                         pqt_reached);
				end
			end
		end
	endgenerate

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign radio_state = state_num_reg;
	assign synth_on    = synth_reg;
	assign synth_cal   = cal_reg;
	assign rx_enable   = rxen_reg;
	assign tx_enable   = txen_reg;
	assign port1_pin5  = pin_reg[0];
	assign port1_pin6  = pin_reg[1];
	assign port1_pin7  = pin_reg[2];

	idle_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		go_idle |=> state_reg == ST_IDLE) else $error("idle strobe did not reach idle");
	no_idle_cal_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		go_idle ##1 1'b1 |-> !synth_cal) else $error("idle strobe started calibration");
	cca_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_RX && (go_tx || go_synth) && !cca_ok && !go_idle && !rx_pkt_done)
		|=> state_reg != ST_RX_TO_TX) else $error("busy channel did not block tx");
	cca_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_RX && go_tx && cca_policy == 2'h0) |=> state_reg == ST_RX_TO_TX ##1 tmr.count == 15'h00f9)
		else $error("tx strobe with policy 00 did not proceed");
	no_retry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_RX && !strobe_valid_reg && !rx_pkt_done) |=> state_reg != ST_RX_TO_TX)
		else $error("tx entered without a strobe");
	tx_abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_TX && go_rx) |=> state_reg == ST_TX_TO_RX && !tx_enable)
		else $error("rx strobe did not abort tx");
	turnaround_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(state_reg == ST_RX_TO_TX) ##249 (state_reg == ST_RX_TO_TX && !go_idle) |=> state_reg != ST_RX_TO_TX)
		else $error("rx to tx turnaround length wrong");
	cal_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg != ST_CAL && state_next == ST_CAL) |=> tmr.count == TMR_W'(CAL_CYCLES_P))
		else $error("calibration not loaded with its length");
	timeout_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_RX && rx_timer_expired && !rx_stay && !rx_pkt_done && !go_idle && !go_tx && !go_synth
		 && !cal_at_end) |=> state_reg == ST_IDLE) else $error("timeout did not return to idle");
	pin_cca_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pincfg_reg[3:0] == PIN_SEL_CCA && $stable(pincfg_reg)) |=> port1_pin5 == $past(cca_ok))
		else $error("pin does not show clear channel");
endmodule : radio_state_ctrl

//--- core/radio_ctrl_pkg.sv
// Purpose: shared constants and types of the radio state controller
// Assumes: one sys_clk cycle per reference oscillator period
// Notes: register map sits on an APB slave, one 32-bit word each
package radio_ctrl_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_STROBE = 8'h00;
	localparam logic [7:0] ADDR_CFG0   = 8'h04;
	localparam logic [7:0] ADDR_CFG1   = 8'h08;
	localparam logic [7:0] ADDR_CFG2   = 8'h0c;
	localparam logic [7:0] ADDR_GAIN1  = 8'h10;
	localparam logic [7:0] ADDR_PINCFG = 8'h14;
	localparam logic [7:0] ADDR_STATE  = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;

	// strobe codes
	localparam logic [3:0] STB_CAL   = 4'h1;
	localparam logic [3:0] STB_RX    = 4'h2;
	localparam logic [3:0] STB_TX    = 4'h3;
	localparam logic [3:0] STB_SYNTH = 4'h4;
	localparam logic [3:0] STB_IDLE  = 4'h5;

	// field positions
	localparam int AUTOCAL_LSB = 4;
	localparam int CCA_LSB     = 4;
	localparam int RXOFF_LSB   = 2;
	localparam int TXOFF_LSB   = 0;
	localparam int QUAL_BIT    = 3;
	localparam int EARLY_BIT   = 4;
	localparam int RELCS_LSB   = 4;
	localparam int PIN_W       = 4;

	// reset values
	localparam logic [7:0]  CFG0_RST   = 8'h00;
	localparam logic [7:0]  CFG1_RST   = 8'h00;
	localparam logic [7:0]  CFG2_RST   = 8'h00;
	localparam logic [7:0]  GAIN1_RST  = 8'h00;
	localparam logic [11:0] PINCFG_RST = 12'h000;

	// pin signal select codes
	localparam logic [3:0] PIN_SEL_PQT = 4'h8;
	localparam logic [3:0] PIN_SEL_CCA = 4'h9;
	localparam logic [3:0] PIN_SEL_CS  = 4'he;

	// relative carrier sense steps in half-dB units (rssi lsb)
	localparam logic signed [8:0] REL_STEP_6DB  = 9'sh00c;
	localparam logic signed [8:0] REL_STEP_10DB = 9'sh014;
	localparam logic signed [8:0] REL_STEP_14DB = 9'sh01c;

	// field encodings
	localparam logic [1:0] OFF_IDLE  = 2'h0;
	localparam logic [1:0] OFF_SYNTH = 2'h1;
	localparam logic [1:0] OFF_TX    = 2'h2;
	localparam logic [1:0] OFF_RX    = 2'h3;
	localparam logic [1:0] CAL_START = 2'h1;
	localparam logic [1:0] CAL_END   = 2'h2;
	localparam logic [1:0] CAL_END4  = 2'h3;

	// timing, in reference periods and in sys_clk cycles
	localparam int CLK_PER_REF        = 1;
	localparam int CAL_REF_PERIODS    = 18739;
	localparam int SETTLE_REF_PERIODS = 2298;
	localparam int TX_RX_REF_PERIODS  = 560;
	localparam int RX_TX_REF_PERIODS  = 250;
	localparam int CAL_CYCLES         = CAL_REF_PERIODS * CLK_PER_REF;
	localparam int SETTLE_CYCLES      = SETTLE_REF_PERIODS * CLK_PER_REF;
	localparam int TX_RX_CYCLES       = TX_RX_REF_PERIODS * CLK_PER_REF;
	localparam int RX_TX_CYCLES       = RX_TX_REF_PERIODS * CLK_PER_REF;
	localparam int TMR_W              = 15;

	typedef enum logic [3:0] {
		ST_IDLE, ST_CAL, ST_SETTLE, ST_RX, ST_TX, ST_SYNTH_READY,
		ST_TX_TO_RX, ST_RX_TO_TX, ST_TX_UNDERFLOW
	} radio_state_t;

	function automatic logic [4:0] state_number(input radio_state_t s);
		case (s)
			ST_IDLE:         state_number = 5'h01;
			ST_CAL:          state_number = 5'h04;
			ST_SETTLE:       state_number = 5'h03;
			ST_RX:           state_number = 5'h0d;
			ST_TX:           state_number = 5'h13;
			ST_SYNTH_READY:  state_number = 5'h12;
			ST_TX_TO_RX:     state_number = 5'h15;
			ST_RX_TO_TX:     state_number = 5'h10;
			ST_TX_UNDERFLOW: state_number = 5'h16;
			default:         state_number = 5'h00;
		endcase
	endfunction : state_number

endpackage : radio_ctrl_pkg

//--- core/timer_if.sv
// Purpose: carrier between the state controller and its transition timer
// Assumes: single sys_clk domain
// Notes: load wins over clear in the same cycle
interface timer_if;
	import radio_ctrl_pkg::*;
	logic             load;
	logic             clear;
	logic [TMR_W-1:0] value;
	logic [TMR_W-1:0] count;
	logic             done;
	modport ctrl (output load, output clear, output value, input count, input done);
	modport tmr  (input load, input clear, input value, output count, output done);
endinterface : timer_if

//--- core/transition_timer.sv
// Purpose: down counter timing calibration, settling and turnaround
// Assumes: loaded value is at least 1
// Notes: done is high in the last cycle of a loaded interval
module transition_timer
	import radio_ctrl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// controller side
	timer_if.tmr     t
);
	logic [TMR_W-1:0] count_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (t.load) begin
			count_reg <= t.value;
		end else if (t.clear) begin
			count_reg <= '0;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	assign t.count = count_reg;
	assign t.done  = (count_reg == {{(TMR_W-1){1'b0}}, 1'b1});

	load_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		t.load |=> count_reg == $past(t.value)) else $error("timer did not take load value");
endmodule : transition_timer

//--- sim/radio_state_ctrl_tb.sv
// Purpose: self-checking bench for the radio state controller
// Assumes: calibration shortened to 20 cycles, one clock per reference period
// Notes: apb master waits for pready; the cycle watchdog bounds every wait
module radio_state_ctrl_tb
	import radio_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic [7:0]  rssi = 8'h00;
	logic        rssi_valid = 1'b0;
	logic        cs_abs = 1'b0;
	logic        pkt_receiving = 1'b0;
	logic        sync_found = 1'b0;
	logic        pqt_reached = 1'b0;
	logic [3:0]  ev = 4'h0;
	wire logic   rx_pkt_done;
	wire logic   rx_timer_expired;
	wire logic   tx_pkt_done;
	wire logic   tx_underflow;
	logic [4:0]  radio_state;
	logic        synth_on;
	logic        synth_cal;
	logic        rx_enable;
	logic        tx_enable;
	logic        port1_pin5;
	logic        port1_pin6;
	logic        port1_pin7;
	int          err_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          n;

	// event pulses share one vector so a single task can raise any of them
	assign {rx_pkt_done, rx_timer_expired, tx_pkt_done, tx_underflow} = ev;

	always #2.5 sys_clk = ~sys_clk;

	radio_state_ctrl #(.CAL_CYCLES_P(20)) radio_state_ctrl_i (
		.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.rssi, .rssi_valid, .cs_abs, .pkt_receiving, .sync_found, .pqt_reached, .rx_pkt_done,
		.rx_timer_expired, .tx_pkt_done, .tx_underflow, .radio_state, .synth_on, .synth_cal,
		.rx_enable, .tx_enable, .port1_pin5, .port1_pin6, .port1_pin7
	);

	task automatic end_sim;
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic stb(input logic [3:0] c);
		apb(ADDR_STROBE, 1'b1, {28'h0, c});
	endtask : stb

	task automatic wait_st(input logic [4:0] exp);
		n = 0;
		while (radio_state !== exp && n < 30000) begin
			@(posedge sys_clk);
			n++;
		end
		chk({27'h0, radio_state}, {27'h0, exp});
	endtask : wait_st

	task automatic pulse(input logic [3:0] m);
		@(posedge sys_clk);
		ev <= m;
		@(posedge sys_clk);
		ev <= 4'h0;
	endtask : pulse

	task automatic rs(input logic [7:0] v);
		@(posedge sys_clk);
		rssi       <= v;
		rssi_valid <= 1'b1;
		@(posedge sys_clk);
		rssi_valid <= 1'b0;
	endtask : rs

	// ceiling well above the roughly 14k cycles the sequence needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		chk({29'h0, radio_state[2:0], synth_on, synth_cal}, 32'h4);
		rst_n <= 1'b1;
		apb(ADDR_STATE, 1'b0, 32'h0);
		chk(rd, 32'h1);
		apb(8'h20, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(ADDR_CFG1, 1'b1, 32'h20);
		stb(STB_RX);
		wait_st(5'h03);
		wait_st(5'h0d);
		chk(n, 2298);
		chk({31'h0, rx_enable}, 32'h1);
		pkt_receiving <= 1'b1;
		stb(STB_TX);
		repeat (300) @(posedge sys_clk);
		chk({27'h0, radio_state}, 32'h0d);
		pkt_receiving <= 1'b0;
		repeat (300) @(posedge sys_clk);
		chk({27'h0, radio_state}, 32'h0d);
		stb(STB_SYNTH);
		wait_st(5'h10);
		wait_st(5'h12);
		chk(n, 250);
		chk({31'h0, synth_on}, 32'h1);
		stb(STB_TX);
		wait_st(5'h13);
		chk({30'h0, tx_enable, rx_enable}, 32'h2);
		stb(STB_RX);
		wait_st(5'h15);
		wait_st(5'h0d);
		chk(n, 560);
		apb(ADDR_CFG1, 1'b1, 32'h07);
		pkt_receiving <= 1'b1;
		stb(STB_TX);
		wait_st(5'h13);
		pkt_receiving <= 1'b0;
		pulse(4'h2);
		wait_st(5'h0d);
		pulse(4'h8);
		wait_st(5'h12);
		stb(STB_TX);
		wait_st(5'h13);
		pulse(4'h1);
		wait_st(5'h16);
		stb(STB_IDLE);
		wait_st(5'h01);
		chk({31'h0, synth_on}, 32'h0);
		stb(STB_CAL);
		wait_st(5'h04);
		chk({31'h0, synth_cal}, 32'h1);
		wait_st(5'h01);
		chk(n, 20);
		apb(ADDR_CFG2, 1'b1, 32'h08);
		stb(STB_RX);
		wait_st(5'h0d);
		sync_found <= 1'b1;
		pulse(4'h4);
		repeat (4) @(posedge sys_clk);
		chk({27'h0, radio_state}, 32'h0d);
		sync_found  <= 1'b0;
		pqt_reached <= 1'b1;
		pulse(4'h4);
		repeat (4) @(posedge sys_clk);
		chk({27'h0, radio_state}, 32'h0d);
		pqt_reached <= 1'b0;
		pulse(4'h4);
		wait_st(5'h01);
		apb(ADDR_CFG2, 1'b1, 32'h10);
		stb(STB_RX);
		wait_st(5'h0d);
		rs(8'h00);
		wait_st(5'h01);
		apb(ADDR_CFG0, 1'b1, 32'h20);
		stb(STB_RX);
		wait_st(5'h0d);
		stb(STB_IDLE);
		repeat (4) @(posedge sys_clk);
		chk({27'h0, radio_state}, 32'h01);
		stb(STB_RX);
		wait_st(5'h0d);
		pulse(4'h4);
		wait_st(5'h04);
		wait_st(5'h01);
		apb(ADDR_CFG1, 1'b1, 32'h10);
		apb(ADDR_PINCFG, 1'b1, 32'h8e9);
		cs_abs <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({29'h0, port1_pin7, port1_pin6, port1_pin5}, 32'h2);
		cs_abs      <= 1'b0;
		pqt_reached <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({29'h0, port1_pin7, port1_pin6, port1_pin5}, 32'h5);
		pqt_reached <= 1'b0;
		apb(ADDR_GAIN1, 1'b1, 32'h10);
		rs(8'h00);
		rs(8'h0b);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h1);
		rs(8'h17);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h6);
		rs(8'h0b);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h1);
		end_sim();
	end

endmodule : radio_state_ctrl_tb
